// file: design/wcs_consts.vh
// Constants for the wireless transmitter status sequencer
`ifndef WCS_CONSTS_VH
`define WCS_CONSTS_VH
// Register byte offsets
`define WCS_REG_CTRL 12'h000
`define WCS_REG_STATE 12'h004
`define WCS_REG_IRQ_STAT 12'h008
`define WCS_REG_IRQ_MASK 12'h00C
// Control field positions
`define WCS_CTRL_ENABLE_BIT 0
`define WCS_CTRL_ENABLE_RST 1'h1
// Interrupt status bit positions
`define WCS_IRQ_FOUND_BIT 0
`define WCS_IRQ_REMOVED_BIT 1
`define WCS_IRQ_FOREIGN_BIT 2
`define WCS_IRQ_ERROR_BIT 3
`define WCS_IRQ_DONE_BIT 4
`define WCS_IRQ_WIDTH 5
`define WCS_IRQ_MASK_RST 5'h00
// Timing
`define WCS_CLK_HZ 100000000
`define WCS_TICK_MS 1
`define WCS_INIT_MS 500
`define WCS_FLASH_MS 1000
`define WCS_TICK_CYC ((`WCS_CLK_HZ / 1000) * `WCS_TICK_MS)
`endif

// file: design/wcs_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module wcs_sync (
   input wire clock,
   input wire rst,
   input wire din,
   output reg dout
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;
   // Stage one feeds only stage two; output changes when stages two and three agree
   always @(posedge clock) begin
      if (rst) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            dout <= s3_ff;
         end
      end
   end
endmodule // wcs_sync
`default_nettype wire

// file: design/wcs_status_seq.v
// Transmitter phase sequencer with status indicators and APB registers
//
// Summary of operation
// [R1] After reset the block lights green for half a second in an init state, then goes to standby.
// [R2] In standby both indicators are dark.
// [R3] A detected receiver in standby moves the block to negotiation before any power is sent.
// [R4] Power delivery is enabled only while a receiver is present.
// [R5] In power transfer the green indicator flashes with a one-second period.
// [R6] A foreign object during charging aborts power and flashes red until the receiver leaves.
// [R7] Any other error during charging aborts power and lights red steadily until the receiver leaves.
// [R8] Communication faults and overvoltage, overcurrent, overpower or overtemperature all count as errors.
// [R9] Without error, charging lasts until the receiver needs no more power, then charge complete is entered.
// [R10] In charge complete the green indicator is lit steadily until the receiver is removed.
// [R11] A receiver-removed event returns the block to standby from any state; the code ignores removal during power-up init.
// [R12] When the receiver asks for no more power the transmitted output is reduced to match.
// [R13] Flash period and init time come from a prescaled millisecond tick, flashing at 50 percent duty.
// [R14] A foreign object and an error in the same cycle lead to the foreign-object fault state.
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "wcs_consts.vh"
module wcs_status_seq #(
   parameter TICK_CYC = `WCS_TICK_CYC,
   parameter INIT_MS = `WCS_INIT_MS,
   parameter FLASH_MS = `WCS_FLASH_MS
) (
   input wire clock,
   input wire rst,
   input wire pinRxPresent,
   input wire pinForeignObj,
   input wire pinCommFault,
   input wire pinOverVolt,
   input wire pinOverCurr,
   input wire pinOverPower,
   input wire pinOverTemp,
   input wire pinNoMorePower,
   input wire negotiateDone,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   output reg ledGreen,
   output reg ledRed,
   output reg powerEnable,
   output reg powerReduce,
   output reg irq
);
   // One-hot phase codes
   localparam [6:0] ST_INIT = 7'h01;
   localparam [6:0] ST_STANDBY = 7'h02;
   localparam [6:0] ST_NEGOT = 7'h04;
   localparam [6:0] ST_XFER = 7'h08;
   localparam [6:0] ST_FOREIGN = 7'h10;
   localparam [6:0] ST_ERROR = 7'h20;
   localparam [6:0] ST_DONE = 7'h40;
   localparam [15:0] HALF_FLASH = FLASH_MS / 2;
   localparam [15:0] INIT_LEN = INIT_MS;

   wire rxPresent;
   wire foreignObj;
   wire commFault;
   wire overVolt;
   wire overCurr;
   wire overPower;
   wire overTemp;
   wire noMorePower;

   // Pin synchronisers
   wcs_sync uSyncPresent (.clock(clock), .rst(rst), .din(pinRxPresent), .dout(rxPresent));
   wcs_sync uSyncForeign (.clock(clock), .rst(rst), .din(pinForeignObj), .dout(foreignObj));
   wcs_sync uSyncComm (.clock(clock), .rst(rst), .din(pinCommFault), .dout(commFault));
   wcs_sync uSyncVolt (.clock(clock), .rst(rst), .din(pinOverVolt), .dout(overVolt));
   wcs_sync uSyncCurr (.clock(clock), .rst(rst), .din(pinOverCurr), .dout(overCurr));
   wcs_sync uSyncPower (.clock(clock), .rst(rst), .din(pinOverPower), .dout(overPower));
   wcs_sync uSyncTemp (.clock(clock), .rst(rst), .din(pinOverTemp), .dout(overTemp));
   wcs_sync uSyncDone (.clock(clock), .rst(rst), .din(pinNoMorePower), .dout(noMorePower));

   reg [6:0] state_ff;
   reg [6:0] nxt_state;
   reg [31:0] presc_ff;
   reg tick_ff;
   reg [15:0] msCnt_ff;
   reg [15:0] nxt_msCnt;
   reg flashOn;
   reg present_ff;
   reg enable_ff;
   reg [`WCS_IRQ_WIDTH-1:0] irqStat_ff;
   reg [`WCS_IRQ_WIDTH-1:0] irqMask_ff;
   reg [`WCS_IRQ_WIDTH-1:0] events;
   wire anyError;
   wire removedEv;
   wire foundEv;
   wire apbAccess;
   wire apbRead;
   wire apbWrite;

   // Error sources merged into one condition
   assign anyError = commFault | overVolt | overCurr | overPower | overTemp; // see [R8]
   assign removedEv = present_ff & ~rxPresent;
   assign foundEv = ~present_ff & rxPresent;
   assign apbAccess = psel & penable & pready;
   assign apbRead = apbAccess & ~pwrite;
   assign apbWrite = apbAccess & pwrite;

   // Millisecond prescaler
   always @(posedge clock) begin
      if (rst) begin
         presc_ff <= 32'h00000000;
         tick_ff <= 1'b0;
      end else if (presc_ff >= TICK_CYC - 1) begin
         presc_ff <= 32'h00000000;
         tick_ff <= 1'b1; // see [R13]
      end else begin
         presc_ff <= presc_ff + 32'h00000001;
         tick_ff <= 1'b0;
      end
   end

   // Phase transitions
   always @* begin
      nxt_state = state_ff;
      nxt_msCnt = msCnt_ff;
      if (tick_ff) begin
         nxt_msCnt = msCnt_ff + 16'h0001;
      end
      case (state_ff)
         ST_INIT: begin
            if (tick_ff && msCnt_ff >= INIT_LEN - 16'h0001) begin
               nxt_state = ST_STANDBY; // see [R1]
               nxt_msCnt = 16'h0000;
            end
         end
         ST_STANDBY: begin
            nxt_msCnt = 16'h0000;
            if (rxPresent && enable_ff) begin
               nxt_state = ST_NEGOT; // see [R3]
            end
         end
         ST_NEGOT: begin
            nxt_msCnt = 16'h0000;
            if (negotiateDone) begin
               nxt_state = ST_XFER;
            end
         end
         ST_XFER: begin
            if (foreignObj) begin
               nxt_state = ST_FOREIGN; // see [R6] [R14]
               nxt_msCnt = 16'h0000;
            end else if (anyError) begin
               nxt_state = ST_ERROR; // see [R7]
            end else if (noMorePower) begin
               nxt_state = ST_DONE; // see [R9]
            end
         end
         ST_FOREIGN: begin
         end
         ST_ERROR: begin
         end
         ST_DONE: begin
         end
         default: begin
            nxt_state = ST_STANDBY;
         end
      endcase
      // Flash counter wraps each period
      if (tick_ff && msCnt_ff >= FLASH_MS - 1 && state_ff != ST_INIT) begin
         nxt_msCnt = 16'h0000;
      end
      // Removal overrides every phase except power-up init
      if (!rxPresent && state_ff != ST_INIT) begin
         nxt_state = ST_STANDBY; // see [R11] [R4]
      end
   end

   // Phase, counter and presence registers
   always @(posedge clock) begin
      if (rst) begin
         state_ff <= ST_INIT;
         msCnt_ff <= 16'h0000;
         present_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         msCnt_ff <= nxt_msCnt;
         present_ff <= rxPresent;
      end
   end

   // Half-period flash level taken from the coming count, so a fresh fault lights at once
   always @* begin
      flashOn = (nxt_msCnt < HALF_FLASH); // see [R13]
   end

   // Indicator and power outputs
   always @(posedge clock) begin
      if (rst) begin
         ledGreen <= 1'b0;
         ledRed <= 1'b0;
         powerEnable <= 1'b0;
         powerReduce <= 1'b0;
      end else begin
         ledGreen <= 1'b0;
         ledRed <= 1'b0;
         powerEnable <= 1'b0;
         powerReduce <= 1'b0;
         case (nxt_state)
            ST_INIT: begin
               ledGreen <= 1'b1; // see [R1]
            end
            ST_STANDBY: begin
               ledGreen <= 1'b0; // see [R2]
            end
            ST_NEGOT: begin
               powerEnable <= 1'b0; // see [R3]
            end
            ST_XFER: begin
               ledGreen <= flashOn; // see [R5]
               powerEnable <= rxPresent; // see [R4]
            end
            ST_FOREIGN: begin
               ledRed <= flashOn; // see [R6]
            end
            ST_ERROR: begin
               ledRed <= 1'b1; // see [R7]
            end
            ST_DONE: begin
               ledGreen <= 1'b1; // see [R10]
               powerReduce <= rxPresent; // see [R12]
            end
            default: begin
               ledGreen <= 1'b0;
            end
         endcase
      end
   end

   // Event vector for sticky status
   always @* begin
      events = {`WCS_IRQ_WIDTH{1'b0}};
      events[`WCS_IRQ_FOUND_BIT] = foundEv;
      events[`WCS_IRQ_REMOVED_BIT] = removedEv;
      events[`WCS_IRQ_FOREIGN_BIT] = (state_ff == ST_XFER) && (nxt_state == ST_FOREIGN);
      events[`WCS_IRQ_ERROR_BIT] = (state_ff == ST_XFER) && (nxt_state == ST_ERROR);
      events[`WCS_IRQ_DONE_BIT] = (state_ff == ST_XFER) && (nxt_state == ST_DONE);
   end

   // Control, mask and sticky status registers; new events win over read clear
   always @(posedge clock) begin
      if (rst) begin
         enable_ff <= `WCS_CTRL_ENABLE_RST;
         irqMask_ff <= `WCS_IRQ_MASK_RST;
         irqStat_ff <= {`WCS_IRQ_WIDTH{1'b0}};
         irq <= 1'b0;
      end else begin
         if (apbWrite && paddr == `WCS_REG_CTRL) begin
            enable_ff <= pwdata[`WCS_CTRL_ENABLE_BIT];
         end
         if (apbWrite && paddr == `WCS_REG_IRQ_MASK) begin
            irqMask_ff <= pwdata[`WCS_IRQ_WIDTH-1:0];
         end
         if (apbRead && paddr == `WCS_REG_IRQ_STAT) begin
            irqStat_ff <= events;
         end else begin
            irqStat_ff <= irqStat_ff | events;
         end
         irq <= |((irqStat_ff | events) & irqMask_ff);
      end
   end

   // APB slave: one wait state, data and error with pready
   always @(posedge clock) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         if (paddr == `WCS_REG_CTRL) begin
            prdata[`WCS_CTRL_ENABLE_BIT] <= enable_ff;
         end else if (paddr == `WCS_REG_STATE) begin
            prdata[6:0] <= state_ff;
         end else if (paddr == `WCS_REG_IRQ_STAT) begin
            prdata[`WCS_IRQ_WIDTH-1:0] <= irqStat_ff;
         end else if (paddr == `WCS_REG_IRQ_MASK) begin
            prdata[`WCS_IRQ_WIDTH-1:0] <= irqMask_ff;
         end else begin
            pslverr <= 1'b1; // Unmapped address
         end
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end
endmodule // wcs_status_seq
`default_nettype wire

// file: verification/wcs_led_model.sv
// Indicator lamp model counting flashes
`timescale 1ns/100ps
`default_nettype none
module wcs_led_model (
   input wire logic clock,
   input wire logic ledGreen,
   input wire logic ledRed,
   output wire logic [15:0] greenRise,
   output wire logic [15:0] redRise
);
   logic gQ = 1'b0;
   logic rQ = 1'b0;
   logic [15:0] gCnt = 16'h0;
   logic [15:0] rCnt = 16'h0;
   // Each lit onset counts as one flash
   always @(posedge clock) begin
      gQ <= ledGreen;
      rQ <= ledRed;
      if (ledGreen && !gQ)
         gCnt <= gCnt + 16'h1;
      if (ledRed && !rQ)
         rCnt <= rCnt + 16'h1;
   end
   assign greenRise = gCnt;
   assign redRise = rCnt;
endmodule // wcs_led_model
`default_nettype wire

// file: verification/wcs_status_seq_chk.sv
// Assertion checker for the status sequencer
`timescale 1ns/100ps
`default_nettype none
module wcs_status_seq_chk #(
   parameter TICK_CYC = 2,
   parameter INIT_MS = 4,
   parameter FLASH_MS = 4
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic pinRxPresent,
   input wire logic negotiateDone,
   input wire logic ledGreen,
   input wire logic ledRed,
   input wire logic powerEnable,
   input wire logic powerReduce
);
   localparam int HALF = TICK_CYC * FLASH_MS / 2;
   localparam int PER = 2 * HALF;
   localparam int INIT_LO = TICK_CYC * INIT_MS - TICK_CYC - 1;
   localparam int INIT_HI = 2 * TICK_CYC + 3;
   logic gQ_ff;
   logic [15:0] run_ff;
   logic [15:0] redOff_ff;
   // Cycles the red lamp has been dark, saturating
   always @(posedge clock) begin
      if (rst)
         redOff_ff <= 16'h00FF;
      else if (ledRed)
         redOff_ff <= 16'h0000;
      else if (redOff_ff != 16'hFFFF)
         redOff_ff <= redOff_ff + 16'h0001;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // Length of the current green run
   always @(posedge clock) begin
      gQ_ff <= ledGreen;
      run_ff <= (ledGreen != gQ_ff) ? 16'h1 : run_ff + 16'h1;
   end
   chk_init_green: assert property ($fell(rst) |=> (ledGreen throughout 1'b1 ##INIT_LO 1'b1) ##[1:INIT_HI] !ledGreen)
      else $error("init green period wrong");
   chk_removed_idle: assert property (!pinRxPresent [*8] |-> !ledRed && !powerEnable && !powerReduce)
      else $error("not idle after removal");
   chk_power_rx: assert property (!pinRxPresent [*6] |-> !powerEnable)
      else $error("power without receiver");
   chk_red_abort: assert property (ledRed |-> !powerEnable && !ledGreen)
      else $error("red lit while charging");
   chk_done_green: assert property (powerReduce |-> ledGreen && !ledRed && !powerEnable)
      else $error("complete state outputs wrong");
   chk_xfer_entry: assert property ($rose(powerEnable) |-> $past(negotiateDone))
      else $error("power began without negotiation");
   chk_flash_half: assert property (ledGreen != gQ_ff && powerEnable && $past(powerEnable, PER)
      |-> run_ff == HALF) else $error("green flash half period wrong");
   chk_fault_entry: assert property ($rose(ledRed) && redOff_ff >= PER |-> $past(powerEnable))
      else $error("fault entered outside charging");
endmodule // wcs_status_seq_chk
bind wcs_status_seq wcs_status_seq_chk #(.TICK_CYC(TICK_CYC), .INIT_MS(INIT_MS), .FLASH_MS(FLASH_MS))
   wcs_status_seq_chk_inst (.clock(clock), .rst(rst), .pinRxPresent(pinRxPresent), .negotiateDone(negotiateDone),
   .ledGreen(ledGreen), .ledRed(ledRed), .powerEnable(powerEnable), .powerReduce(powerReduce));
`default_nettype wire

// file: verification/tb_wcs_status_seq.sv
// Self-checking bench for the status sequencer
`timescale 1ns/100ps
`default_nettype none
`include "wcs_consts.vh"
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin failures++; \
   $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module tb_wcs_status_seq;
   localparam int PER = 8;
   logic clock = 0, rst = 1, rx = 0, nego = 0, noMore = 0, psel = 0, penable = 0, pwrite = 0;
   logic [5:0] flt = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   logic pready, pslverr, ledGreen, ledRed, powerEnable, powerReduce, irq, e;
   logic [15:0] gRise, rRise;
   int failures = 0, testsRun = 0;
   wcs_status_seq #(.TICK_CYC(2), .INIT_MS(4), .FLASH_MS(4)) wcs_status_seq_inst (.clock(clock), .rst(rst),
      .pinRxPresent(rx), .pinForeignObj(flt[0]), .pinCommFault(flt[1]), .pinOverVolt(flt[2]),
      .pinOverCurr(flt[3]), .pinOverPower(flt[4]), .pinOverTemp(flt[5]), .pinNoMorePower(noMore),
      .negotiateDone(nego), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ledGreen(ledGreen), .ledRed(ledRed),
      .powerEnable(powerEnable), .powerReduce(powerReduce), .irq(irq));
   wcs_led_model wcs_led_model_inst (.clock(clock), .ledGreen(ledGreen), .ledRed(ledRed),
      .greenRise(gRise), .redRise(rRise));
   // Clock
   initial begin
      forever #5 clock = ~clock;
   end
   task print_verdict;
      begin
         $display("failures %0d comparisons %0d", failures, testsRun);
         if (failures == 0 && testsRun > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // One APB transfer; result left in q and e
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clock);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge clock);
            n++;
         end while (pready !== 1'b1 && n < 20);
         if (n >= 20) begin
            failures++;
            print_verdict;
         end
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge clock);
      end
   endtask
   task waitState(input logic [6:0] s);
      int n;
      begin
         n = 0;
         do begin
            apb(1'b0, `WCS_REG_STATE, 32'h0);
            n++;
         end while (q[6:0] !== s && n < 60);
         `CHK(q[6:0], s)
         if (q[6:0] !== s)
            print_verdict;
      end
   endtask
   task countRise(input logic [15:0] ng, input logic [15:0] nr);
      logic [15:0] g0;
      logic [15:0] r0;
      begin
         g0 = gRise;
         r0 = rRise;
         repeat (3 * PER) @(posedge clock);
         `CHK(gRise - g0, ng)
         `CHK(rRise - r0, nr)
      end
   endtask
   task tInit;
      begin
         @(posedge clock);
         @(posedge clock);
         `CHK(ledGreen, 1'b1)
         waitState(7'h02);
         `CHK({ledGreen, ledRed, powerEnable, powerReduce}, 4'h0)
         apb(1'b0, `WCS_REG_CTRL, 32'h0);
         `CHK(q, 32'h1)
         apb(1'b0, `WCS_REG_IRQ_MASK, 32'h0);
         `CHK(q, 32'h0)
      end
   endtask
   task startXfer;
      begin
         rx <= 1'b1;
         waitState(7'h04);
         `CHK(powerEnable, 1'b0)
         nego <= 1'b1;
         @(posedge clock);
         nego <= 1'b0;
         waitState(7'h08);
         `CHK(powerEnable, 1'b1)
      end
   endtask
   task tCharge;
      begin
         startXfer;
         countRise(16'h3, 16'h0);
         noMore <= 1'b1;
         waitState(7'h40);
         noMore <= 1'b0;
         `CHK({ledGreen, ledRed, powerEnable, powerReduce}, 4'h9)
         countRise(16'h0, 16'h0);
         rx <= 1'b0;
         waitState(7'h02);
         `CHK({ledGreen, ledRed, powerEnable, powerReduce}, 4'h0)
         startXfer;
         rx <= 1'b0;
         waitState(7'h02);
         `CHK(powerEnable, 1'b0)
      end
   endtask
   task tFault(input logic [5:0] f, input logic [6:0] s, input logic [15:0] nr);
      begin
         startXfer;
         flt <= f;
         waitState(s);
         flt <= 6'h0;
         `CHK(powerEnable, 1'b0)
         countRise(16'h0, nr);
         if (nr == 16'h0)
            `CHK(ledRed, 1'b1)
         waitState(s);
         rx <= 1'b0;
         waitState(7'h02);
      end
   endtask
   task tIrq;
      begin
         apb(1'b1, `WCS_REG_IRQ_MASK, 32'h1F);
         apb(1'b0, `WCS_REG_IRQ_STAT, 32'h0);
         @(posedge clock);
         `CHK(irq, 1'b0)
         rx <= 1'b1;
         waitState(7'h04);
         `CHK(irq, 1'b1)
         apb(1'b0, `WCS_REG_IRQ_STAT, 32'h0);
         `CHK(q[`WCS_IRQ_FOUND_BIT], 1'b1)
         @(posedge clock);
         `CHK(irq, 1'b0)
         apb(1'b1, `WCS_REG_IRQ_MASK, 32'h0);
         rx <= 1'b0;
         waitState(7'h02);
         `CHK(irq, 1'b0)
         apb(1'b0, `WCS_REG_IRQ_STAT, 32'h0);
         `CHK(q[`WCS_IRQ_REMOVED_BIT], 1'b1)
         apb(1'b1, 12'h010, 32'hFF);
         `CHK(e, 1'b1)
      end
   endtask
   // Main sequence
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      tInit;
      tCharge;
      for (int i = 0; i < 6; i++)
         tFault(6'h1 << i, (i == 0) ? 7'h10 : 7'h20, (i == 0) ? 16'h3 : 16'h0);
      tFault(6'h3, 7'h10, 16'h3);
      tIrq;
      print_verdict;
   end
endmodule // tb_wcs_status_seq
`default_nettype wire
